// [shared/ldsub_pkg.sv]
// Package: constants and types for the byte/half-word load unit
package ldsub_pkg;
	// ----------------------------------------
	// Widths and fixed values
	// ----------------------------------------
	localparam int unsigned DATA_W = 32;
	localparam int unsigned IMM_W = 9;
	localparam int unsigned REG_IDX_W = 6;
	localparam logic [5:0] LINK_REG_IDX = 6'h3F;
	localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
	// Control-register space: addresses at or above this base
	localparam logic [31:0] CTRL_SPACE_BASE = 32'hFFFF_0000;
	// Issue-to-writeback distance in bundles (one bundle per clock)
	localparam int unsigned LOAD_LATENCY = 2;
	localparam logic [1:0] RESET_STATE = 2'h0;

	// ----------------------------------------
	// Operation codes
	// ----------------------------------------
	typedef enum logic [2:0] {
		OP_NONE = 3'h0,
		OP_BYTE_S = 3'h1,
		OP_BYTE_U = 3'h2,
		OP_HALF_S = 3'h3,
		OP_HALF_U = 3'h4
	} load_op_t;

	typedef struct packed {
		logic valid;
		load_op_t op;
		logic dismissable;
		logic [5:0] dest;
		logic [31:0] base;
		logic [8:0] imm;
	} load_req_t;

	typedef struct packed {
		logic data_breakpoint_exception;
		logic control_space_violation;
		logic data_translation_fault;
		logic misalignment_trap;
	} load_exc_t;

	typedef struct packed {
		logic valid;
		logic [5:0] dest;
		logic [31:0] data;
	} load_wb_t;

	// Pipeline stage states, Gray coded along the usual path
	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_ISSUED = 2'h1,
		ST_WRITE = 2'h3
	} stage_t;
endpackage

// [hw/load_extend.sv]
// Module: extension of a returned byte or half-word to 32 bits
`timescale 1ns/1ps
`default_nettype none
module load_extend
	import ldsub_pkg::*;
(
	// Selection
	input wire ldsub_pkg::load_op_t i_op,
	input wire logic i_zero,
	// Data
	input wire logic [31:0] i_raw,
	output logic [31:0] o_value
);
	always_comb begin
		case (i_op)
			OP_BYTE_S: o_value = {{24{i_raw[7]}}, i_raw[7:0]}; // [RULE1]
			OP_BYTE_U: o_value = {24'h000000, i_raw[7:0]}; // [RULE2]
			OP_HALF_S: o_value = {{16{i_raw[15]}}, i_raw[15:0]}; // [RULE3]
			OP_HALF_U: o_value = {16'h0000, i_raw[15:0]};
			default: o_value = ZERO_WORD;
		endcase
		if (i_zero) begin
			o_value = ZERO_WORD; // [RULE9]
		end
	end
endmodule // load_extend
`default_nettype wire

// [hw/byte_halfword_load_unit.sv]
// Module: byte and half-word load execution unit
// What this block does
// [RULE1] Signed byte loads sign-extend eight bits
// [RULE2] Unsigned byte loads zero-extend eight bits
// [RULE3] Signed half-word loads sign-extend sixteen bits
// [RULE4] Issuer never targets link register sixty-three
// [RULE5] At most one load/store per bundle
// [RULE6] Result written two bundles after issue
// [RULE7] Half-word loads: breakpoint, control, translation, misalign
// [RULE8] Byte loads never raise misalignment trap
// [RULE9] Dismissable control-space load writes zero, no fault
// [RULE10] Address is base plus extended immediate; breakpoint first
// [RULE11] Control-space normal load faults, no memory read
`timescale 1ns/1ps
`default_nettype none
module byte_halfword_load_unit
	import ldsub_pkg::*;
(
	// Clock and reset
	input wire logic i_core_clk,
	input wire logic i_reset_n,
	// Issue
	input wire ldsub_pkg::load_req_t i_req,
	// Breakpoint match, combinational on the address
	output logic [31:0] o_check_addr,
	input wire logic i_breakpoint_hit,
	// Memory read
	output logic o_mem_read,
	output logic [31:0] o_mem_addr,
	output logic o_mem_half,
	input wire logic i_mem_valid,
	input wire logic [31:0] i_mem_data,
	input wire logic i_translation_fault,
	// Exceptions and writeback
	output ldsub_pkg::load_exc_t o_exc,
	output ldsub_pkg::load_wb_t o_wb
);
	// ----------------------------------------
	// Address forming
	// ----------------------------------------
	logic [31:0] imm_ext;
	logic [31:0] eff_addr;

	// The immediate is sign-extended to a full word and the sum wraps modulo 2^32
	assign imm_ext = {{23{i_req.imm[8]}}, i_req.imm}; // [RULE10]
	assign eff_addr = i_req.base + imm_ext; // [RULE10]
	// The breakpoint unit answers for this address within the same cycle
	assign o_check_addr = eff_addr;

	// ----------------------------------------
	// Operation decode
	// ----------------------------------------
	logic go;
	logic is_half;
	logic in_ctrl;
	logic misaligned;

	// Only one load/store operation per bundle; the issuer keeps to that [RULE5]
	assign go = i_req.valid && (i_req.op != OP_NONE);
	assign is_half = (i_req.op == OP_HALF_S) || (i_req.op == OP_HALF_U);
	assign in_ctrl = (eff_addr >= CTRL_SPACE_BASE);
	// Byte accesses are never misaligned [RULE8]
	// Alignment belongs to the memory access, so control space skips it [RULE9]
	assign misaligned = is_half && eff_addr[0] && !in_ctrl;
	// Link register as target is left to the issuer and not checked here [RULE4]

	// ----------------------------------------
	// Issue-cycle checks
	// ----------------------------------------
	load_exc_t issue_exc;
	logic accept;
	logic mem_req;

	// Priority: breakpoint, control space, misalignment; translation comes later
	always_comb begin
		issue_exc = '0;
		accept = 1'b0;
		mem_req = 1'b0;
		if (go) begin
			if (i_breakpoint_hit) begin
				issue_exc.data_breakpoint_exception = 1'b1; // [RULE10]
			end else if (in_ctrl && !i_req.dismissable) begin
				issue_exc.control_space_violation = 1'b1; // [RULE11] [RULE7]
			end else if (misaligned) begin
				issue_exc.misalignment_trap = 1'b1; // [RULE7]
			end else begin
				accept = 1'b1;
				// A dismissed control-space load never reaches memory
				mem_req = !in_ctrl; // [RULE9] [RULE11]
			end
		end
	end

	assign o_mem_read = mem_req;
	assign o_mem_addr = eff_addr;
	assign o_mem_half = is_half;

	// ----------------------------------------
	// Load in flight
	// ----------------------------------------
	stage_t state;
	stage_t next_state;
	load_op_t op_q;
	load_op_t next_op_q;
	logic [5:0] dest_q;
	logic [5:0] next_dest_q;
	logic zero_q;
	logic next_zero_q;
	logic live_q;
	logic next_live_q;

	always_comb begin
		next_state = ST_IDLE;
		next_op_q = op_q;
		next_dest_q = dest_q;
		next_zero_q = 1'b0;
		next_live_q = 1'b0;
		if (accept) begin
			next_state = ST_ISSUED;
			next_op_q = i_req.op;
			next_dest_q = i_req.dest;
			// Remember that the result is forced to zero
			next_zero_q = in_ctrl; // [RULE9]
			next_live_q = 1'b1;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			state <= ST_IDLE;
			op_q <= OP_NONE;
			dest_q <= 6'h00;
			zero_q <= 1'b0;
			live_q <= 1'b0;
		end else begin
			state <= next_state;
			op_q <= next_op_q;
			dest_q <= next_dest_q;
			zero_q <= next_zero_q;
			live_q <= next_live_q;
		end
	end

	// ----------------------------------------
	// Memory response, exceptions and writeback
	// ----------------------------------------
	logic [31:0] ext_value;
	load_exc_t next_exc;
	load_wb_t next_wb;

	load_extend u_extend (
		.i_op(op_q),
		.i_zero(zero_q),
		.i_raw(i_mem_data),
		.o_value(ext_value)
	);

	// A missing memory answer in the cycle after issue drops the load silently
	always_comb begin
		next_exc = issue_exc;
		next_wb = '0;
		case (state)
			ST_ISSUED: begin
				if (live_q) begin
					if (!zero_q && i_translation_fault) begin
						next_exc.data_translation_fault = 1'b1; // [RULE7] [RULE8]
					end else if (zero_q || i_mem_valid) begin
						// Registered here, so the value lands two bundles after issue
						next_wb.valid = 1'b1; // [RULE6]
						next_wb.dest = dest_q;
						next_wb.data = ext_value; // [RULE1] [RULE2] [RULE3]
					end
				end
			end
			ST_IDLE: begin
			end
			default: begin
			end
		endcase
	end

	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_exc <= '0;
			o_wb <= '0;
		end else begin
			o_exc <= next_exc;
			o_wb <= next_wb;
		end
	end
endmodule // byte_halfword_load_unit
`default_nettype wire

// [dv/mem_model.sv]
// Memory partner: answers each read one cycle later
`timescale 1ns/1ps
`default_nettype none
module mem_model (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// Read request from the load unit
	input wire logic i_rd,
	input wire logic [31:0] i_a,
	// Translation fault to report for this read
	input wire logic i_flt,
	// Answer, one cycle after the request
	output logic o_v,
	output logic o_tf,
	output logic [31:0] o_d
);
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_v <= 1'b0;
			o_tf <= 1'b0;
			o_d <= 32'h0;
		end else begin
			o_v <= i_rd;
			o_tf <= i_rd && i_flt;
			// Between reads the data bus shows the inverse of its last value
			o_d <= i_rd ? 32'(i_a * 32'h9E37_79B1) : ~o_d;
		end
	end
endmodule // mem_model
`default_nettype wire

// [dv/ld_sva.sv]
// Assertions on the load unit ports
`timescale 1ns/1ps
`default_nettype none
module ld_sva (
	// Clock and reset
	input wire logic i_core_clk,
	input wire logic i_reset_n,
	// Issue and address check
	input wire ldsub_pkg::load_req_t i_req,
	input wire logic [31:0] o_check_addr,
	input wire logic i_breakpoint_hit,
	// Memory side
	input wire logic o_mem_read,
	input wire logic i_mem_valid,
	input wire logic i_translation_fault,
	// Results
	input wire ldsub_pkg::load_exc_t o_exc,
	input wire ldsub_pkg::load_wb_t o_wb
);
	import ldsub_pkg::*;
	wire logic [31:0] ea = i_req.base + 32'($signed(i_req.imm));
	wire logic go = i_req.valid && (i_req.op != OP_NONE);
	wire logic hw = (i_req.op == OP_HALF_S) || (i_req.op == OP_HALF_U);
	wire logic h = go && i_breakpoint_hit;
	wire logic c = go && !i_breakpoint_hit && (ea >= CTRL_SPACE_BASE);
	wire logic odd = go && !i_breakpoint_hit && hw && ea[0] && (ea < CTRL_SPACE_BASE);
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (!i_reset_n);
	AST_ADDR: assert property (go |-> o_check_addr == ea)
		else $error("address");
	AST_BRK: assert property (h |-> !o_mem_read ##1
		(o_exc.data_breakpoint_exception && !o_exc.control_space_violation &&
		!o_exc.misalignment_trap)) else $error("breakpoint");
	AST_CTRL: assert property (c && !i_req.dismissable |-> !o_mem_read ##1
		(o_exc.control_space_violation && !o_exc.data_breakpoint_exception &&
		!o_exc.misalignment_trap)) else $error("control");
	AST_DIS: assert property (c && i_req.dismissable |-> !o_mem_read ##1
		(!o_exc.control_space_violation && !o_exc.misalignment_trap) ##1
		(o_wb.valid && o_wb.data == ZERO_WORD)) else $error("dismiss");
	AST_MIS: assert property (odd |-> !o_mem_read ##1 o_exc.misalignment_trap)
		else $error("misaligned half-word");
	AST_NOMIS: assert property (go && !hw |-> ##1 !o_exc.misalignment_trap)
		else $error("misalign");
	AST_WB: assert property (o_mem_read ##1 (i_mem_valid && !i_translation_fault) |->
		##1 o_wb.valid) else $error("writeback");
	AST_TF: assert property (o_mem_read ##1 i_translation_fault |->
		##1 (o_exc.data_translation_fault && !o_wb.valid)) else $error("fault");
	AST_HS: assert property (o_wb.valid && $past(i_req.op, 2) == OP_HALF_S |->
		o_wb.data[31:16] == {16{o_wb.data[15]}}) else $error("sign");
	cover property (o_wb.valid);
	cover property (o_exc.control_space_violation);
	cover property (o_exc.misalignment_trap);
	cover property (o_exc.data_translation_fault);
	cover property (c && i_req.dismissable ##2 o_wb.valid);
endmodule // ld_sva
bind byte_halfword_load_unit ld_sva u_sva (.*);
`default_nettype wire

// [dv/tb_top.sv]
// Self-checking bench for the byte and half-word load unit
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import ldsub_pkg::*;
	// Multiplier that the memory partner uses to make data from an address
	localparam logic [31:0] MEM_HASH = 32'h9E37_79B1;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic hit = 1'b0;
	logic flt = 1'b0;
	logic rd;
	logic mh;
	logic mv;
	logic tf;
	logic [31:0] ca;
	logic [31:0] ma;
	logic [31:0] md;
	load_req_t req = '0;
	load_exc_t exc;
	load_wb_t wb;
	int fail_count = 0;
	int compares = 0;
	always #25 clk = ~clk;
	byte_halfword_load_unit DUT (
		.i_core_clk(clk),
		.i_reset_n(rst_n),
		.i_req(req),
		.o_check_addr(ca),
		.i_breakpoint_hit(hit),
		.o_mem_read(rd),
		.o_mem_addr(ma),
		.o_mem_half(mh),
		.i_mem_valid(mv),
		.i_mem_data(md),
		.i_translation_fault(tf),
		.o_exc(exc),
		.o_wb(wb)
	);
	mem_model MEM (
		.i_clk(clk),
		.i_rst_n(rst_n),
		.i_rd(rd),
		.i_a(ma),
		.i_flt(flt),
		.o_v(mv),
		.o_tf(tf),
		.o_d(md)
	);
	function automatic logic [31:0] ext(load_op_t op, logic [31:0] r);
		case (op)
			OP_BYTE_S: return {{24{r[7]}}, r[7:0]};
			OP_BYTE_U: return {24'h00_0000, r[7:0]};
			OP_HALF_S: return {{16{r[15]}}, r[15:0]};
			default: return {16'h0000, r[15:0]};
		endcase
	endfunction
	// Data the partner returns for a read of this address
	function automatic logic [31:0] mem_word(logic [31:0] a);
		return 32'(a * MEM_HASH);
	endfunction
	task automatic chk_mem(logic [33:0] g, logic [33:0] e);
		compares++;
		if (g !== e) begin
			fail_count++;
			$display("BAD t=%0t mem got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic chk_exc(logic [3:0] g, logic [3:0] e);
		compares++;
		if (g !== e) begin
			fail_count++;
			$display("BAD t=%0t exc got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic chk_wb(logic [38:0] g, logic [38:0] e);
		compares++;
		if (g !== e) begin
			fail_count++;
			$display("BAD t=%0t wb got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic ld(load_op_t op, logic d, logic [31:0] b, logic [8:0] im, logic h, logic f);
		logic [31:0] a;
		logic [5:0] t;
		logic c;
		logic m;
		logic r;
		logic v;
		a = b + 32'($signed(im));
		t = 6'($urandom % 63);
		c = (a >= CTRL_SPACE_BASE) && !h;
		m = (op > OP_BYTE_U) && a[0] && !h && !c;
		r = !h && !c && !m;
		v = (r && !f) || (c && d);
		@(posedge clk);
		req <= '{1'b1, op, d, t, b, im};
		hit <= h;
		flt <= f;
		@(negedge clk);
		chk_mem({rd, ma, mh}, {r, a, op > OP_BYTE_U});
		@(posedge clk);
		req <= '0;
		hit <= 1'b0;
		flt <= 1'b0;
		@(negedge clk);
		chk_exc(exc, {h, c && !d, 1'b0, m});
		@(negedge clk);
		chk_exc(exc, {2'b00, r && f, 1'b0});
		chk_wb(wb, v ? {1'b1, t, c ? ZERO_WORD : ext(op, mem_word(a))} : 39'h0);
	endtask
	task automatic end_sim;
		$display("compares=%0d fail_count=%0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	initial begin
		#200us;
		fail_count++;
		end_sim;
	end
	initial begin
		load_op_t op;
		logic dis;
		logic brk;
		logic tr;
		logic [31:0] base;
		void'($urandom(40));
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		ld(OP_HALF_S, 1'b0, CTRL_SPACE_BASE, 9'h000, 1'b0, 1'b0);
		ld(OP_BYTE_U, 1'b1, 32'hFFFF_FFF0, 9'h00F, 1'b0, 1'b0);
		ld(OP_HALF_S, 1'b1, CTRL_SPACE_BASE, 9'h001, 1'b0, 1'b0);
		ld(OP_HALF_U, 1'b0, 32'hFFFF_FFFF, 9'h002, 1'b0, 1'b1);
		ld(OP_BYTE_S, 1'b0, 32'h0000_1001, 9'h1FF, 1'b1, 1'b1);
		ld(OP_HALF_S, 1'b0, 32'h0000_1000, 9'h002, 1'b0, 1'b1);
		ld(OP_BYTE_S, 1'b0, 32'h0000_2001, 9'h000, 1'b0, 1'b0);
		repeat (300) begin
			op = load_op_t'(3'(1 + $urandom % 4));
			dis = 1'($urandom);
			brk = ($urandom % 8) == 0;
			tr = ($urandom % 6) == 0;
			base = $urandom;
			if (($urandom % 8) == 0) begin
				base = CTRL_SPACE_BASE | (base & 32'h0000_FFFF);
			end
			ld(op, dis, base, 9'($urandom), brk, tr);
		end
		end_sim;
	end
endmodule // tb_top
`default_nettype wire
